// [rtl/mef_pkg.sv]
/*
 * Shared constants and carrier types of the meter event flag and enable block.
 * Assumes a single 50 MHz bus clock and word-wide AHB-Lite accesses only.
 */
package mef_pkg;

   // Register indices; byte address is four times the index
   localparam logic [15:0] MEF_IDX_STATUS0  = 16'he502;
   localparam logic [15:0] MEF_IDX_INTERRUPT_STATUS_WORD_ONE  = 16'he503;
   localparam logic [15:0] MEF_IDX_ENABLE0  = 16'he50a;
   localparam logic [15:0] MEF_IDX_ENABLE1  = 16'he50b;
   localparam logic [15:0] MEF_IDX_ACC_CFG  = 16'he600;
   localparam logic [15:0] MEF_IDX_MM_LEVEL = 16'he601;
   localparam logic [15:0] MEF_IDX_CPEAK    = 16'he602;
   localparam logic [15:0] MEF_IDX_VOLTAGE_PEAK_VALUE    = 16'he603;
   localparam logic [15:0] MEF_IDX_LINECNT  = 16'he604;

   // Word zero event and enable bits
   localparam int MEF_EN0_W          = 11;
   localparam int MEF_B0_HALFFULL_LO = 0;
   localparam int MEF_B0_LINE_DONE   = 5;
   localparam int MEF_B0_ACT_SIGN_LO = 6;
   localparam int MEF_B0_PULSE1_SUM  = 9;
   localparam int MEF_B0_REACT_A     = 10;

   // Word one status bits
   localparam int MEF_B1_RESET_DONE  = 15;
   localparam int MEF_B1_MISMATCH    = 20;
   localparam int MEF_B1_RSV_ONE     = 21;
   localparam int MEF_B1_RSV_ZERO    = 22;
   localparam int MEF_B1_CPEAK       = 23;
   localparam int MEF_B1_VOLTAGE_PEAK_VALUE       = 24;

   localparam logic [31:0] MEF_STS1_STICKY = 32'h0190_8000;
   localparam logic [31:0] MEF_STS1_FIXED1 = 32'h0020_0000;
   localparam logic [31:0] MEF_EN1_MASK    = 32'h0190_0000;

   // Accumulation configuration bits
   localparam int MEF_CFG_ACT_SEL    = 6;
   localparam int MEF_CFG_REACT_SEL  = 7;
   localparam int MEF_CFG_LINE_MODE  = 8;
   localparam int MEF_CFG_W          = 9;

   // Reset values
   localparam logic [MEF_EN0_W-1:0] MEF_RST_EN0  = 11'h000;
   localparam logic [31:0]          MEF_RST_EN1  = 32'h0000_0000;
   localparam logic [31:0]          MEF_RST_STS1 = 32'h0020_8000;
   localparam logic [MEF_CFG_W-1:0] MEF_RST_CFG  = 9'h000;
   localparam logic [23:0]          MEF_RST_LVL  = 24'h00_0000;
   localparam logic [15:0]          MEF_RST_LINE = 16'h0000;

   localparam int MEF_CATS     = 5;
   localparam int MEF_SMP_W    = 24;
   localparam int MEF_PEAK_PH  = 24;

   typedef struct packed {
      logic [MEF_CATS-1:0][2:0] energy_b30;     // Bit 30 of each phase accumulator per category
      logic [2:0]               act_sign_tot;
      logic [2:0]               act_sign_fund;
      logic                     react_a_sign_tot;
      logic                     react_a_sign_fund;
      logic                     pulse1_sum_sign;
      logic                     line_cycle_done;
      logic                     curr_peak_end;
      logic                     volt_peak_end;
      logic                     power_mode_return;
   } mef_events_t;

   typedef struct packed {
      logic [2:0]  phase;
      logic [23:0] value;
   } mef_peak_t;

   typedef struct packed {
      logic                        valid;
      logic signed [MEF_SMP_W-1:0] summed_phase_current;
      logic signed [MEF_SMP_W-1:0] neutral_current_sample;
   } mef_mismatch_in_t;

endpackage

// [rtl/mef_mismatch.sv]
/*
 * Neutral mismatch comparator: flags when the summed phase current and the
 * neutral sample differ by more than the programmed level.
 * Assumes both samples arrive together, qualified by a valid strobe.
 */
`timescale 1ns/100ps
`default_nettype none

module mef_mismatch
   import mef_pkg::*;
(
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire mef_mismatch_in_t smp,
   input  wire logic [23:0]      level,
   output logic                  above
);

   logic signed [MEF_SMP_W:0] diff;
   logic        [MEF_SMP_W:0] magnitude;
   logic                      above_next;
   logic                      above_reg;

   ////////////////////////////////////////////////////////////////////////////
   // One guard bit keeps full-scale opposite samples from wrapping
   always_comb
   begin
      diff       = {smp.summed_phase_current[MEF_SMP_W-1], smp.summed_phase_current}
                   - {smp.neutral_current_sample[MEF_SMP_W-1], smp.neutral_current_sample};
      magnitude  = diff[MEF_SMP_W] ? (MEF_SMP_W+1)'(-diff) : diff;
      above_next = smp.valid && (magnitude > {1'b0, level});
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         above_reg <= 1'b0;
      else
         above_reg <= above_next;
   end

   assign above = above_reg;

endmodule

`default_nettype wire

// [rtl/mef_event_flags.sv]
/*
 * Interrupt status and enable logic of a polyphase meter, reached over AHB-Lite.
 * Assumes event inputs synchronous to hclk and a single zero-wait-state bus master.
 */
`timescale 1ns/100ps
`default_nettype none

module mef_event_flags
   import mef_pkg::*;
#(
   parameter bit HAS_NEUTRAL  = 1'b1,
   parameter bit HAS_FUND     = 1'b1,
   parameter bit HAS_REACTIVE = 1'b1
)
(
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic                  hreadyout,
   output logic [31:0]           hrdata,
   output logic                  hresp,
   input  wire mef_events_t      events,
   input  wire mef_mismatch_in_t mismatch_in,
   input  wire mef_peak_t        curr_peak_in,
   input  wire mef_peak_t        volt_peak_in,
   output logic                  irq_n,
   output logic [15:0]           half_cycle_count
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decoding

   function automatic logic [16:0] reg_index(input logic [31:0] addr);
      // Bit 16 marks an address inside the register window
      reg_index = {(addr[31:18] == 14'h0000) && (addr[1:0] == 2'b00), addr[17:2]};
   endfunction

   // Register state is declared up front because event detection reads it
   logic [MEF_EN0_W-1:0] en0_reg,  en0_next;
   logic [MEF_EN0_W-1:0] sts0_reg, sts0_next;
   logic [31:0]          en1_reg,  en1_next;
   logic [31:0]          sts1_reg, sts1_next;
   logic [MEF_CFG_W-1:0] cfg_reg,  cfg_next;
   logic [23:0]          lvl_reg,  lvl_next;
   logic [15:0]          line_reg, line_next;
   mef_peak_t            cpk_reg,  cpk_next;
   mef_peak_t            vpk_reg,  vpk_next;
   logic [31:0]          rdata_next;
   logic                 irq_n_next;

   logic        addr_phase;
   logic [16:0] addr_idx;
   logic        wr_pend_reg;
   logic        wr_pend_next;
   logic [16:0] wr_idx_reg;
   logic [16:0] wr_idx_next;

   assign addr_phase = hsel && hready && htrans[1];
   assign addr_idx   = reg_index(haddr);

   always_comb
   begin
      wr_pend_next = addr_phase && hwrite;
      wr_idx_next  = addr_phase ? reg_index(haddr) : wr_idx_reg;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg  <= 17'h0_0000;
      end
      else
      begin
         wr_pend_reg <= wr_pend_next;
         wr_idx_reg  <= wr_idx_next;
      end
   end

   logic wr_en0, wr_en1, wr_sts0, wr_sts1, wr_cfg, wr_lvl, wr_line;

   assign wr_en0  = wr_pend_reg && (wr_idx_reg == {1'b1, MEF_IDX_ENABLE0});
   assign wr_en1  = wr_pend_reg && (wr_idx_reg == {1'b1, MEF_IDX_ENABLE1});
   assign wr_sts0 = wr_pend_reg && (wr_idx_reg == {1'b1, MEF_IDX_STATUS0});
   assign wr_sts1 = wr_pend_reg && (wr_idx_reg == {1'b1, MEF_IDX_INTERRUPT_STATUS_WORD_ONE});
   assign wr_cfg  = wr_pend_reg && (wr_idx_reg == {1'b1, MEF_IDX_ACC_CFG});
   assign wr_lvl  = wr_pend_reg && (wr_idx_reg == {1'b1, MEF_IDX_MM_LEVEL});
   assign wr_line = wr_pend_reg && (wr_idx_reg == {1'b1, MEF_IDX_LINECNT});

   ////////////////////////////////////////////////////////////////////////////
   // Event detection

   mef_events_t prev_reg;
   logic        armed_reg;
   logic        mm_above;

   mef_mismatch u_mismatch
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .smp     (mismatch_in),
      .level   (lvl_reg),
      .above   (mm_above)
   );

   // Categories a variant lacks never raise their half-full event
   localparam logic [MEF_CATS-1:0] CAT_ON = {1'b1, HAS_FUND, HAS_REACTIVE, HAS_FUND, 1'b1};

   logic [MEF_CATS-1:0]  hf_evt;
   logic [MEF_EN0_W-1:0] ev0;
   logic [31:0]          ev1;
   logic [2:0]           act_chg;
   logic                 react_chg;

   genvar g;
   generate
      for (g = 0; g < MEF_CATS; g++)
      begin : g_halffull
         // Any toggle of bit 30, either direction, is one half-full event
         assign hf_evt[g] = CAT_ON[g] && armed_reg
                            && |(events.energy_b30[g] ^ prev_reg.energy_b30[g]);
      end
   endgenerate

   always_comb
   begin
      // Both sources are tracked so flipping the select causes no false event
      act_chg   = cfg_reg[MEF_CFG_ACT_SEL] ? (events.act_sign_fund ^ prev_reg.act_sign_fund)
                                           : (events.act_sign_tot ^ prev_reg.act_sign_tot);
      react_chg = HAS_REACTIVE && (cfg_reg[MEF_CFG_REACT_SEL]
                  ? (events.react_a_sign_fund ^ prev_reg.react_a_sign_fund)
                  : (events.react_a_sign_tot ^ prev_reg.react_a_sign_tot));
      ev0 = '0;
      ev0[MEF_B0_HALFFULL_LO +: MEF_CATS] = hf_evt;
      ev0[MEF_B0_LINE_DONE]               = events.line_cycle_done && cfg_reg[MEF_CFG_LINE_MODE];
      ev0[MEF_B0_ACT_SIGN_LO +: 3]        = armed_reg ? act_chg : 3'h0;
      ev0[MEF_B0_PULSE1_SUM]              = armed_reg && (events.pulse1_sum_sign ^ prev_reg.pulse1_sum_sign);
      ev0[MEF_B0_REACT_A]                 = armed_reg && react_chg;
      ev1 = '0;
      ev1[MEF_B1_RESET_DONE] = events.power_mode_return;
      ev1[MEF_B1_MISMATCH]   = HAS_NEUTRAL && mm_above;
      ev1[MEF_B1_CPEAK]      = events.curr_peak_end;
      ev1[MEF_B1_VOLTAGE_PEAK_VALUE]      = events.volt_peak_end;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file

   always_comb
   begin
      en0_next  = wr_en0  ? hwdata[MEF_EN0_W-1:0] : en0_reg;
      en1_next  = wr_en1  ? (hwdata & MEF_EN1_MASK) : en1_reg;
      cfg_next  = wr_cfg  ? hwdata[MEF_CFG_W-1:0] : cfg_reg;
      lvl_next  = wr_lvl  ? hwdata[23:0] : lvl_reg;
      line_next = wr_line ? hwdata[15:0] : line_reg;
      // Set wins over a write-one-to-clear landing in the same cycle
      sts0_next = (sts0_reg & ~(wr_sts0 ? hwdata[MEF_EN0_W-1:0] : '0)) | ev0;
      sts1_next = ((((sts1_reg & ~(wr_sts1 ? hwdata : 32'h0000_0000)) | ev1) & MEF_STS1_STICKY)
                   | MEF_STS1_FIXED1);
      cpk_next  = events.curr_peak_end ? curr_peak_in : cpk_reg;
      vpk_next  = events.volt_peak_end ? volt_peak_in : vpk_reg;
      // Reset complete bypasses every enable
      irq_n_next = !((|(sts0_next & en0_next)) || (|(sts1_next & en1_next))
                     || sts1_next[MEF_B1_RESET_DONE]);
   end

   // Reads see next values so a write directly followed by a read is coherent
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      if (addr_phase && !hwrite && addr_idx[16])
      begin
         case (addr_idx[15:0])
            MEF_IDX_STATUS0:  rdata_next = {21'h00_0000, sts0_next};
            MEF_IDX_INTERRUPT_STATUS_WORD_ONE:  rdata_next = sts1_next;
            MEF_IDX_ENABLE0:  rdata_next = {21'h00_0000, en0_next};
            MEF_IDX_ENABLE1:  rdata_next = en1_next;
            MEF_IDX_ACC_CFG:  rdata_next = {23'h00_0000, cfg_next};
            MEF_IDX_MM_LEVEL: rdata_next = {8'h00, lvl_next};
            MEF_IDX_CPEAK:    rdata_next = {5'h00, cpk_next};
            MEF_IDX_VOLTAGE_PEAK_VALUE:    rdata_next = {5'h00, vpk_next};
            MEF_IDX_LINECNT:  rdata_next = {16'h0000, line_next};
            default:          rdata_next = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus response: zero wait states and always OKAY, so no error path exists

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hrdata    <= rdata_next;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software-written control state

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         en0_reg  <= MEF_RST_EN0;
         en1_reg  <= MEF_RST_EN1;
         cfg_reg  <= MEF_RST_CFG;
         lvl_reg  <= MEF_RST_LVL;
         line_reg <= MEF_RST_LINE;
      end
      else
      begin
         en0_reg  <= en0_next;
         en1_reg  <= en1_next;
         cfg_reg  <= cfg_next;
         lvl_reg  <= lvl_next;
         line_reg <= line_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky flags and the interrupt line; both move on the same edge

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sts0_reg <= '0;
         sts1_reg <= MEF_RST_STS1;
         irq_n    <= 1'b1;
      end
      else
      begin
         sts0_reg <= sts0_next;
         sts1_reg <= sts1_next;
         irq_n    <= irq_n_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Peak capture

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cpk_reg <= '0;
         vpk_reg <= '0;
      end
      else
      begin
         cpk_reg <= cpk_next;
         vpk_reg <= vpk_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event history; the first edge after reset only learns the input levels,
   // otherwise a level that differs from zero would read as a false toggle

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         prev_reg  <= '0;
         armed_reg <= 1'b0;
      end
      else
      begin
         prev_reg  <= events;
         armed_reg <= 1'b1;
      end
   end

   assign half_cycle_count = line_reg;

endmodule

`default_nettype wire

// [sim/mef_event_flags_properties.sv]
/*
 * Checker of mef_event_flags port behaviour, bound to every instance.
 * Assumes one AHB-Lite slave whose hreadyout is the bus hready.
 */
`timescale 1ns/100ps
`default_nettype none

module mef_event_flags_properties
   import mef_pkg::*;
(
   input wire logic             hclk,
   input wire logic             hresetn,
   input wire logic             hsel,
   input wire logic [31:0]      haddr,
   input wire logic [1:0]       htrans,
   input wire logic             hwrite,
   input wire logic             hready,
   input wire logic             hreadyout,
   input wire logic [31:0]      hrdata,
   input wire logic             hresp,
   input wire mef_events_t      events,
   input wire mef_mismatch_in_t mismatch_in,
   input wire logic             irq_n
);
   ////////////////////////////////////////
   logic       take;
   logic       s1;
   logic       rd_dp;
   logic       rd_s1;
   logic       wr_dp;
   logic [1:0] settle;

   assign take = hsel && hready && htrans[1];
   assign s1   = haddr == {14'h0000, MEF_IDX_INTERRUPT_STATUS_WORD_ONE, 2'b00};

   // Settle counter keeps reset-release edges out of the quiet-line check
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         rd_dp  <= 1'b0;
         rd_s1  <= 1'b0;
         wr_dp  <= 1'b0;
         settle <= 2'h0;
      end
      else
      begin
         rd_dp  <= take && !hwrite;
         rd_s1  <= take && !hwrite && s1;
         wr_dp  <= take && hwrite;
         settle <= (settle == 2'h3) ? settle : settle + 2'h1;
      end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   ////////////////////////////////////////
   a_status_fixed_bits: assert property (rd_s1 |-> hrdata[22:21] == 2'b01 && hrdata[31:25] == 7'h00)
      else $error("status word fixed bits wrong");
   a_reset_done_irq: assert property (events.power_mode_return |=> !irq_n)
      else $error("power mode return left interrupt high");
   a_irq_after_reset: assert property (settle == 2'h2 |-> !irq_n)
      else $error("interrupt high after reset");
   a_cpeak_flag_read: assert property (events.curr_peak_end ##1 (take && !hwrite && s1) |=> hrdata[23])
      else $error("current peak flag not set");
   a_voltage_peak_value_flag_read: assert property (events.volt_peak_end ##1 (take && !hwrite && s1) |=> hrdata[24])
      else $error("voltage peak flag not set");
   a_irq_needs_cause: assert property (irq_n && settle == 2'h3 && !wr_dp && !$past(wr_dp) && $stable(events)
      && !mismatch_in.valid && !$past(mismatch_in.valid) |=> irq_n)
      else $error("interrupt fell without a cause");
   a_zero_wait: assert property (hreadyout)
      else $error("wait state inserted");
   a_resp_okay: assert property (!hresp)
      else $error("error response");
   a_rdata_idle_zero: assert property (!rd_dp |-> hrdata == 32'h0000_0000)
      else $error("read data outside a read");

   c_power_return: cover property (events.power_mode_return);
   c_peak_read: cover property (rd_s1 && hrdata[23]);
   c_irq_fall: cover property ($fell(irq_n));
endmodule

bind mef_event_flags mef_event_flags_properties chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
   .hreadyout, .hrdata, .hresp, .events, .mismatch_in, .irq_n);

`default_nettype wire

// [sim/mef_event_flags_tb.sv]
/*
 * Self-checking bench of mef_event_flags through AHB-Lite register tasks.
 * Assumes the block is the only slave, so hready is its own hreadyout.
 */
`timescale 1ns/100ps
`default_nettype none

module mef_event_flags_tb
   import mef_pkg::*;
;
   logic             hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic             hready, hreadyout, hresp, irq_n;
   logic [1:0]       htrans = 2'h0;
   logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [15:0]      half_cycle_count;
   mef_events_t      ev = '0;
   mef_mismatch_in_t mm = '0;
   mef_peak_t        cpk = '0, vpk = '0;
   int               err_total = 0, comparisons = 0;

   assign hready = hreadyout;
   always #10 hclk = ~hclk;

   mef_event_flags dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .events(ev), .mismatch_in(mm), .curr_peak_in(cpk), .volt_peak_in(vpk), .irq_n(irq_n),
      .half_cycle_count(half_cycle_count));

   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   // Waits on hready rather than assuming zero wait states
   task automatic xfer(input logic w, input logic [15:0] i, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {14'h0000, i, 2'b00};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [15:0] i, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, i, d, q);
   endtask

   task automatic rdc(input logic [15:0] i, input logic [31:0] exp, input string m);
      logic [31:0] q;
      xfer(1'b0, i, 32'h0, q);
      chk(q, exp, m);
   endtask

   task automatic irqc(input logic exp);
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      chk({31'h0, irq_n}, {31'h0, exp}, "interrupt line");
      @(posedge hclk);
   endtask

   task automatic fire(input int k);
      @(posedge hclk);
      case (k)
         0, 1, 2, 3, 4: ev.energy_b30[k][k % 3] <= ~ev.energy_b30[k][k % 3];
         5: ev.line_cycle_done <= 1'b1;
         6, 7, 8: ev.act_sign_fund[k - 6] <= ~ev.act_sign_fund[k - 6];
         9: ev.pulse1_sum_sign <= ~ev.pulse1_sum_sign;
         10: ev.react_a_sign_fund <= ~ev.react_a_sign_fund;
         11: ev.curr_peak_end <= 1'b1;
         12: ev.volt_peak_end <= 1'b1;
         13: ev.power_mode_return <= 1'b1;
         default: ev.act_sign_tot[0] <= ~ev.act_sign_tot[0];
      endcase
      @(posedge hclk);
      ev.line_cycle_done <= 1'b0;
      ev.curr_peak_end <= 1'b0;
      ev.volt_peak_end <= 1'b0;
      ev.power_mode_return <= 1'b0;
   endtask

   task automatic mmp(input logic [23:0] s, input logic [23:0] n);
      @(posedge hclk);
      mm <= {1'b1, s, n};
      @(posedge hclk);
      mm.valid <= 1'b0;
   endtask

   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   ////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      irqc(1'b0);
      rdc(MEF_IDX_INTERRUPT_STATUS_WORD_ONE, 32'h0020_8000, "interrupt_status_word_one reset");
      rdc(MEF_IDX_ENABLE0, 32'h0000_0000, "enable0 reset");
      rdc(16'h1234, 32'h0000_0000, "unmapped read");
      wr(MEF_IDX_INTERRUPT_STATUS_WORD_ONE, 32'h0000_8000);
      rdc(MEF_IDX_INTERRUPT_STATUS_WORD_ONE, 32'h0020_0000, "interrupt_status_word_one clear");
      irqc(1'b1);
      wr(MEF_IDX_ACC_CFG, 32'h0000_00c0);
      fire(5);
      fire(14);
      rdc(MEF_IDX_STATUS0, 32'h0000_0000, "mode off or source unselected");
      wr(MEF_IDX_ACC_CFG, 32'h0000_01c0);
      wr(MEF_IDX_LINECNT, 32'h0001_abcd);
      rdc(MEF_IDX_LINECNT, 32'h0000_abcd, "half cycle count readback");
      chk({16'h0000, half_cycle_count}, 32'h0000_abcd, "half cycle count output");
      wr(MEF_IDX_MM_LEVEL, 32'h0000_0064);
      for (int k = 0; k <= 10; k++)
      begin
         fire(k);
         rdc(MEF_IDX_STATUS0, 32'h1 << k, "event flag");
         irqc(1'b1);
         wr(MEF_IDX_ENABLE0, 32'h1 << k);
         rdc(MEF_IDX_ENABLE0, 32'h1 << k, "enable0 readback");
         irqc(1'b0);
         wr(MEF_IDX_STATUS0, 32'h1 << k);
         irqc(1'b1);
      end
      wr(MEF_IDX_ENABLE0, 32'hffff_ffff);
      rdc(MEF_IDX_ENABLE0, 32'h0000_07ff, "enable0 width");
      mmp(24'h000096, 24'h000032);
      rdc(MEF_IDX_INTERRUPT_STATUS_WORD_ONE, 32'h0020_0000, "difference equal to level");
      mmp(24'hffffcd, 24'h000032);
      rdc(MEF_IDX_INTERRUPT_STATUS_WORD_ONE, 32'h0030_0000, "difference above level");
      cpk <= {3'h2, 24'h123456};
      fire(11);
      rdc(MEF_IDX_INTERRUPT_STATUS_WORD_ONE, 32'h00b0_0000, "current peak flag");
      rdc(MEF_IDX_CPEAK, 32'h0212_3456, "current peak value");
      wr(MEF_IDX_ENABLE1, 32'hffff_ffff);
      rdc(MEF_IDX_ENABLE1, 32'h0190_0000, "enable1 width");
      irqc(1'b0);
      vpk <= {3'h4, 24'h00abcd};
      fire(12);
      rdc(MEF_IDX_INTERRUPT_STATUS_WORD_ONE, 32'h01b0_0000, "voltage peak flag");
      rdc(MEF_IDX_VOLTAGE_PEAK_VALUE, 32'h0400_abcd, "voltage peak value");
      wr(MEF_IDX_INTERRUPT_STATUS_WORD_ONE, 32'h0190_0000);
      rdc(MEF_IDX_INTERRUPT_STATUS_WORD_ONE, 32'h0020_0000, "interrupt_status_word_one flags cleared");
      irqc(1'b1);
      fire(13);
      irqc(1'b0);
      rdc(MEF_IDX_INTERRUPT_STATUS_WORD_ONE, 32'h0020_8000, "power mode return");
      test_done();
   end

   // The sequence needs under 2000 cycles
   initial
   begin
      repeat (5000) @(posedge hclk);
      err_total++;
      test_done();
   end
endmodule

`default_nettype wire
